// File: inc/mpseq_if.sv
// Interface joining host and module over the two open-collector lines
`timescale 1ns/1ps
`default_nettype none
interface mpseq_if;
   logic toggle_oe_n;
   logic emerg_oe_n;
   logic toggle_line;
   logic emerg_line;
   logic power_good;
   // Open collector with pull-up modelled here in the interface: each line follows toggle_oe_n or emerg_oe_n
   assign toggle_line = toggle_oe_n;
   assign emerg_line = emerg_oe_n;
   modport host (output toggle_oe_n, output emerg_oe_n,
                 input toggle_line, input emerg_line, input power_good);
   modport dev (input toggle_line, input emerg_line, output power_good);
endinterface : mpseq_if
`default_nettype wire

// File: inc/mpseq_pkg.sv
// Package of timing constants and states for the power sequencer pair
package mpseq_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned TOGGLE_MIN_MS = 1000;
   localparam int unsigned BOOT_WAIT_MS = 900;
   localparam int unsigned EMERG_MIN_MS = 200;
   localparam int unsigned TOGGLE_CYC = TOGGLE_MIN_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned BOOT_CYC = BOOT_WAIT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned EMERG_CYC = EMERG_MIN_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned DETACH_CYC = 16;
   localparam int unsigned PWRUP_CYC = 16;
   localparam int unsigned CNT_W = 32;

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MPSEQ_OFF = 3'b000,
      MPSEQ_PWRUP = 3'b001,
      MPSEQ_ON = 3'b010,
      MPSEQ_WAIT_REL = 3'b011,
      MPSEQ_DETACH = 3'b100
   } mpseq_dev_st_t;

   typedef enum logic [2:0] {
      MPSEQ_H_IDLE = 3'b000,
      MPSEQ_H_PULSE = 3'b001,
      MPSEQ_H_WAIT_PG = 3'b010,
      MPSEQ_H_BOOT = 3'b011,
      MPSEQ_H_WAIT_OFF = 3'b100,
      MPSEQ_H_EMERG = 3'b101
   } mpseq_host_st_t;
endpackage : mpseq_pkg

// File: src/mpseq_dev.sv
// Module end: power state machine driven by toggle and emergency lines
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Host holds toggle low at least 1 s
// - Toggle line has internal pull-up
// - Host only pulls toggle low, open collector
// - Host releases 900 ms after power good
// - Shutdown uses same 1 s low pulse
// - Power down starts only after toggle release; sw_off_in starts the detach and power down with no toggle press
// - Power good low once powered off
// - Detach request sent before normal shutdown
// - Emergency off low at least 200 ms
// - Emergency off: immediate, no detach
// - Emergency off reserved for hangs only
// - Retry once, then emergency off, restart; host waits in MPSEQ_H_WAIT_PG with no retry or emergency off
// - Emergency line open collector only
module mpseq_dev #(
   parameter int unsigned TOGGLE_CYCLES = mpseq_pkg::TOGGLE_CYC
) (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic sw_off_in,
   output logic detach_req_out,
   output logic powered_out,
   mpseq_if.dev link
);
   import mpseq_pkg::*;

   mpseq_dev_st_t st_r;
   logic [CNT_W-1:0] low_cnt_r;
   logic [CNT_W-1:0] cnt_r;
   logic tog_prev_r;
   logic pg_r;
   logic long_low;
   logic low_hold_r;

   // Line reads high when released, via the pull-up in the interface
   assign long_low = (low_cnt_r >= CNT_W'(TOGGLE_CYCLES));
   assign link.power_good = pg_r;

   // ----------------------------------------------------------------
   // Toggle low-time measurement
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         low_cnt_r <= '0;
         tog_prev_r <= 1'b1;
      end else begin
         tog_prev_r <= link.toggle_line;
         if (link.toggle_line) begin
            low_cnt_r <= '0;
         end else if (!long_low) begin
            low_cnt_r <= low_cnt_r + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Power state machine
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         st_r <= MPSEQ_OFF;
         cnt_r <= '0;
         pg_r <= 1'b0;
         detach_req_out <= 1'b0;
         powered_out <= 1'b0;
      end else begin
         detach_req_out <= 1'b0;
         if (!link.emerg_line && st_r != MPSEQ_OFF) begin
            st_r <= MPSEQ_OFF;
            pg_r <= 1'b0;
            powered_out <= 1'b0;
            cnt_r <= '0;
         end else begin
            unique case (st_r)
               MPSEQ_OFF: begin
                  if (long_low && link.emerg_line) begin
                     cnt_r <= '0;
                     st_r <= MPSEQ_PWRUP;
                  end
               end
               MPSEQ_PWRUP: begin
                  cnt_r <= cnt_r + 1'b1;
                  if (cnt_r >= CNT_W'(PWRUP_CYC - 1)) begin
                     pg_r <= 1'b1;
                     powered_out <= 1'b1;
                     st_r <= MPSEQ_ON;
                  end
               end
               MPSEQ_ON: begin
                  // A new press must start from a released line
                  if (sw_off_in) begin
                     detach_req_out <= 1'b1;
                     cnt_r <= '0;
                     st_r <= MPSEQ_DETACH;
                  end else if (!link.toggle_line && tog_prev_r) begin
                     st_r <= MPSEQ_WAIT_REL;
                  end
               end
               MPSEQ_WAIT_REL: begin
                  // Short press is ignored; long press handled below
                  if (link.toggle_line) begin
                     st_r <= MPSEQ_ON;
                  end
               end
               MPSEQ_DETACH: begin
                  cnt_r <= cnt_r + 1'b1;
                  if (cnt_r >= CNT_W'(DETACH_CYC - 1)) begin
                     pg_r <= 1'b0;
                     powered_out <= 1'b0;
                     st_r <= MPSEQ_OFF;
                  end
               end
               default: st_r <= MPSEQ_OFF;
            endcase
            // Shutdown on release after a long press
            if (st_r == MPSEQ_WAIT_REL && link.toggle_line && !tog_prev_r
                && (low_hold_r || long_low)) begin
               detach_req_out <= 1'b1;
               cnt_r <= '0;
               st_r <= MPSEQ_DETACH;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Remembers a long press until release
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         low_hold_r <= 1'b0;
      end else if (st_r != MPSEQ_WAIT_REL) begin
         low_hold_r <= 1'b0;
      end else if (long_low) begin
         low_hold_r <= 1'b1;
      end
   end
endmodule : mpseq_dev
`default_nettype wire

// File: src/mpseq_host.sv
// Host end: times toggle and emergency-off pulses
`timescale 1ns/1ps
`default_nettype none
module mpseq_host #(
   parameter int unsigned TOGGLE_CYCLES = mpseq_pkg::TOGGLE_CYC,
   parameter int unsigned BOOT_CYCLES = mpseq_pkg::BOOT_CYC,
   parameter int unsigned EMERG_CYCLES = mpseq_pkg::EMERG_CYC
) (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic power_on_in,
   input wire logic power_off_in,
   input wire logic emerg_off_in,
   output logic busy_out,
   output logic is_on_out,
   mpseq_if.host link
);
   import mpseq_pkg::*;

   mpseq_host_st_t st_r;
   logic [CNT_W-1:0] cnt_r;
   logic going_on_r;
   logic tog_oe_n_r;
   logic em_oe_n_r;
   logic pg_seen_r;

   assign link.toggle_oe_n = tog_oe_n_r;
   assign link.emerg_oe_n = em_oe_n_r;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         st_r <= MPSEQ_H_IDLE;
         cnt_r <= '0;
         going_on_r <= 1'b0;
         tog_oe_n_r <= 1'b1;
         em_oe_n_r <= 1'b1;
      end else begin
         unique case (st_r)
            MPSEQ_H_IDLE: begin
               cnt_r <= '0;
               if (emerg_off_in) begin
                  em_oe_n_r <= 1'b0;
                  st_r <= MPSEQ_H_EMERG;
               end else if (power_on_in && !link.power_good) begin
                  tog_oe_n_r <= 1'b0;
                  going_on_r <= 1'b1;
                  st_r <= MPSEQ_H_PULSE;
               end else if (power_off_in && link.power_good) begin
                  tog_oe_n_r <= 1'b0;
                  going_on_r <= 1'b0;
                  st_r <= MPSEQ_H_PULSE;
               end
            end
            MPSEQ_H_PULSE: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r >= CNT_W'(TOGGLE_CYCLES - 1)) begin
                  cnt_r <= '0;
                  if (going_on_r) begin
                     st_r <= MPSEQ_H_WAIT_PG;
                  end else begin
                     tog_oe_n_r <= 1'b1;
                     st_r <= MPSEQ_H_WAIT_OFF;
                  end
               end
            end
            MPSEQ_H_WAIT_PG: begin
               if (link.power_good) begin
                  st_r <= MPSEQ_H_BOOT;
               end
            end
            MPSEQ_H_BOOT: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r >= CNT_W'(BOOT_CYCLES - 1)) begin
                  tog_oe_n_r <= 1'b1;
                  cnt_r <= '0;
                  st_r <= MPSEQ_H_IDLE;
               end
            end
            MPSEQ_H_WAIT_OFF: begin
               if (!link.power_good) begin
                  st_r <= MPSEQ_H_IDLE;
               end
            end
            MPSEQ_H_EMERG: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r >= CNT_W'(EMERG_CYCLES - 1)) begin
                  em_oe_n_r <= 1'b1;
                  cnt_r <= '0;
                  st_r <= MPSEQ_H_IDLE;
               end
            end
            default: st_r <= MPSEQ_H_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Status
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         busy_out <= 1'b0;
         pg_seen_r <= 1'b0;
      end else begin
         busy_out <= (st_r != MPSEQ_H_IDLE);
         pg_seen_r <= link.power_good;
      end
   end

   assign is_on_out = pg_seen_r;
endmodule : mpseq_host
`default_nettype wire

// File: test/mpseq_properties.sv
// Checker of the line protocol between host and module
`timescale 1ns/1ps
`default_nettype none
module mpseq_properties #(
   parameter int unsigned TOGGLE_CYCLES = 50,
   parameter int unsigned BOOT_CYCLES = 40,
   parameter int unsigned EMERG_CYCLES = 20
) (
   input wire logic mclk_in,
   input wire logic srst_in,
   input wire logic toggle_oe_n,
   input wire logic emerg_oe_n,
   input wire logic toggle_line,
   input wire logic emerg_line,
   input wire logic power_good
);
   // ----
   // Low-time and power-good age counters
   // ----
   logic [15:0] tlow_r;
   logic [15:0] elow_r;
   logic [15:0] pg_age_r;
   always_ff @(posedge mclk_in) begin
      if (srst_in || toggle_oe_n)
         tlow_r <= '0;
      else if (~&tlow_r)
         tlow_r <= tlow_r + 16'h1;
   end
   always_ff @(posedge mclk_in) begin
      if (srst_in || emerg_oe_n)
         elow_r <= '0;
      else if (~&elow_r)
         elow_r <= elow_r + 16'h1;
   end
   always_ff @(posedge mclk_in) begin
      if (srst_in || !power_good)
         pg_age_r <= '0;
      else if (~&pg_age_r)
         pg_age_r <= pg_age_r + 16'h1;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   a_toggle_min_low: assert property ($rose(toggle_oe_n) |->
      tlow_r >= TOGGLE_CYCLES) else $error("toggle pulse too short");
   a_boot_wait: assert property ($rose(toggle_oe_n) && power_good |->
      pg_age_r >= BOOT_CYCLES) else $error("toggle released before boot");
   a_emerg_min_low: assert property ($rose(emerg_oe_n) |->
      elow_r >= EMERG_CYCLES) else $error("emergency pulse too short");
   a_line_pulled_up: assert property (toggle_oe_n && emerg_oe_n |->
      toggle_line && emerg_line) else $error("released line not high");
   a_pg_after_pulse: assert property ($rose(power_good) |->
      !toggle_line && tlow_r >= TOGGLE_CYCLES) else $error("early power good");
   a_off_after_release: assert property ($fell(power_good) |->
      !$past(emerg_line) || $past(toggle_line, 8)) else $error("early power down");
   a_emerg_at_once: assert property (!emerg_line && power_good |=>
      !power_good) else $error("emergency off not immediate");
   a_no_overlap: assert property (!toggle_oe_n |->
      emerg_oe_n) else $error("both lines pulled together");
endmodule : mpseq_properties
`default_nettype wire

// File: test/mpseq_tb_top.sv
// Testbench of host and module ends joined over the lines
`timescale 1ns/1ps
`default_nettype none
module mpseq_tb_top;
   localparam int unsigned TC = 50;
   localparam int unsigned BC = 40;
   localparam int unsigned EC = 20;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic pon = 1'b0;
   logic poff = 1'b0;
   logic eoff = 1'b0;
   logic sw_off = 1'b0;
   logic busy, is_on, det, pwr, det_seen;
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   int wn;
   mpseq_if la ();
   mpseq_if lb ();
   mpseq_host #(.TOGGLE_CYCLES(TC), .BOOT_CYCLES(BC), .EMERG_CYCLES(EC))
      i_mpseq_host (.mclk_in(mclk), .srst_in(srst), .power_on_in(pon),
      .power_off_in(poff), .emerg_off_in(eoff), .busy_out(busy),
      .is_on_out(is_on), .link(la));
   mpseq_dev #(.TOGGLE_CYCLES(TC)) i_mpseq_dev (.mclk_in(mclk),
      .srst_in(srst), .sw_off_in(sw_off), .detach_req_out(det),
      .powered_out(pwr), .link(la));
   mpseq_dev #(.TOGGLE_CYCLES(TC)) i_mpseq_dev_b (.mclk_in(mclk),
      .srst_in(srst), .sw_off_in(1'b0), .detach_req_out(),
      .powered_out(), .link(lb));
   mpseq_properties #(.TOGGLE_CYCLES(TC), .BOOT_CYCLES(BC),
      .EMERG_CYCLES(EC)) i_mpseq_properties (.mclk_in(mclk),
      .srst_in(srst), .toggle_oe_n(la.toggle_oe_n),
      .emerg_oe_n(la.emerg_oe_n), .toggle_line(la.toggle_line),
      .emerg_line(la.emerg_line), .power_good(la.power_good));
   // ----
   // Clock, timeout and detach monitor
   // ----
   initial forever #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (det === 1'b1)
         det_seen <= 1'b1;
      if (cyc == 20000) begin
         error_cnt++;
         $display("[ERR] %0t timeout", $time);
         test_done();
      end
   end
   // ----
   // Tasks
   // ----
   task test_done();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   task chk(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %b expected %b", $time, got, exp);
      end
   endtask : chk
   task wait_for(input int sel, input logic v);
      logic s;
      wn = 0;
      do begin
         @(negedge mclk);
         wn++;
         s = (sel == 0) ? busy : (sel == 1) ? lb.power_good : la.power_good;
      end while (s !== v && wn < 2000);
   endtask : wait_for
   task host_req(input int k);
      @(negedge mclk);
      pon = (k == 0);
      poff = (k == 1);
      eoff = (k == 2);
      @(negedge mclk);
      pon = 1'b0;
      poff = 1'b0;
      eoff = 1'b0;
      wait_for(0, 1'b0);
   endtask : host_req
   // ----
   // Main sequence
   // ----
   initial begin
      det_seen = 1'b0;
      lb.toggle_oe_n = 1'b1;
      lb.emerg_oe_n = 1'b1;
      repeat (8) @(negedge mclk);
      srst = 1'b0;
      chk(la.toggle_line, 1'b1);
      chk(la.emerg_line, 1'b1);
      host_req(1);
      chk(la.power_good, 1'b0);
      host_req(0);
      chk(is_on, 1'b1);
      chk(pwr, 1'b1);
      det_seen = 1'b0;
      host_req(1);
      chk(det_seen, 1'b1);
      chk(la.power_good, 1'b0);
      chk(is_on, 1'b0);
      host_req(0);
      det_seen = 1'b0;
      host_req(2);
      chk(det_seen, 1'b0);
      chk(pwr, 1'b0);
      host_req(0);
      det_seen = 1'b0;
      sw_off = 1'b1;
      @(negedge mclk);
      sw_off = 1'b0;
      wait_for(2, 1'b0);
      chk(det_seen, 1'b1);
      chk(la.power_good, 1'b0);
      // Second module end, lines driven by the bench
      lb.toggle_oe_n = 1'b0;
      wait_for(1, 1'b1);
      chk(wn >= TC, 1'b1);
      repeat (BC) @(negedge mclk);
      lb.toggle_oe_n = 1'b1;
      repeat (30) @(negedge mclk);
      chk(lb.power_good, 1'b1);
      lb.toggle_oe_n = 1'b0;
      repeat (3 * TC) @(negedge mclk);
      chk(lb.power_good, 1'b1);
      lb.toggle_oe_n = 1'b1;
      wait_for(1, 1'b0);
      chk(wn < 40, 1'b1);
      chk(lb.power_good, 1'b0);
      lb.toggle_oe_n = 1'b0;
      repeat (TC / 2) @(negedge mclk);
      lb.toggle_oe_n = 1'b1;
      repeat (60) @(negedge mclk);
      chk(lb.power_good, 1'b0);
      test_done();
   end
endmodule : mpseq_tb_top
`default_nettype wire
